/* rtl/pwm_compare_regs.vh */
// constants for the pwm output compare unit
// assumes inclusion by bare name from the design files
`ifndef PWM_COMPARE_REGS_VH
`define PWM_COMPARE_REGS_VH
// first control word fields
`define CLK_SEL_HI      12
`define CLK_SEL_LO      10
`define MODE_HI         2
`define MODE_LO         0
// second control word fields
`define SYNC_SEL_HI     4
`define SYNC_SEL_LO     0
`define TRIG_BIT        7
`define SYNC_SELF       5'h1f
// compare modes
`define MODE_OFF        3'h0
`define MODE_EDGE_PWM   3'h6
`define MODE_CENTER_PWM 3'h7
// clock source codes: 0-3 timer prescaler ticks, 7 instruction clock
`define CLK_SYS         3'h7
`define CNT_W           16
`define CNT_ZERO        16'h0000
`define CNT_ONE         16'h0001
`endif

/* rtl/tick_select.v */
// clock source selection for the compare time base
// assumes prescaler ticks are single-cycle pulses on core_clk
`timescale 1ns/100ps
`default_nettype none
`include "pwm_compare_regs.vh"
module tick_select (
	// clock and reset
	input  wire       core_clk,
	input  wire       sys_rst,
	// selection
	input  wire [2:0] clk_sel,
	input  wire [3:0] prescale_tick,
	// advance pulse
	output reg        tick_reg
);
	always @(posedge core_clk) begin
		if (sys_rst) begin
			tick_reg <= 1'b0;
		end else if (clk_sel == `CLK_SYS) begin
			tick_reg <= 1'b1;
		end else if (clk_sel[2]) begin
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= prescale_tick[clk_sel[1:0]];
		end
	end
endmodule
`default_nettype wire

/* rtl/compare_unit_pwm_mode.v */
// pwm mode of an output compare unit with double-buffered duty and period
// assumes control inputs synchronous to core_clk; fault pins are active high
//
// Functional notes
// - edge-aligned and center-aligned waveforms, chosen by the mode field
// - shadow duty and period registers are internal, not visible outside
// - sync select 0x1f with trigger bit clear means self-synchronous running
// - clock source field bits 12:10 of first control word picks time base
// - mode field bits 2:0 of first control word selects pwm mode
// - three fault enables individually gate fault pins onto the output
// - fault handling relies on compare interrupt flag; software enables it
// - timer clock source uses that timer's prescaler output, not its output
// - compare writes any time; new values take effect at period match, or at the bottom in center mode
// - all values zero keeps the pin low, zero percent duty
// - secondary above period keeps the pin high, full duty
// - edge period equals period value plus one, center period twice the period value, times tick time and prescale
// - resolution is log2 of clock over pwm rate times prescale, 16 max
// - primary match drives active level, secondary match returns default
// - compare flag set on each secondary match in double compare modes
`timescale 1ns/100ps
`default_nettype none
`include "pwm_compare_regs.vh"
module compare_unit_pwm_mode (
	// clock and reset
	input  wire        core_clk,
	input  wire        sys_rst,
	// first and second control words
	input  wire [15:0] first_control_word,
	input  wire [15:0] second_control_word,
	input  wire [2:0]  fault_input_enables,
	// software-visible values
	input  wire [15:0] primary_compare_value,
	input  wire [15:0] secondary_compare_value,
	input  wire [15:0] timer_period_value,
	// time base ticks and fault pins
	input  wire [3:0]  prescale_tick,
	input  wire [2:0]  fault_pins,
	// flag clear from software
	input  wire        irq_flag_clear,
	// outputs
	output reg         pulse_output_pin,
	output reg         compare_irq_flag,
	output reg         fault_active,
	output reg  [15:0] timer_count_value
);
	// ************************************************************
	// decode
	// ************************************************************
	wire [2:0] mode = first_control_word[`MODE_HI:`MODE_LO];
	wire [2:0] clk_sel = first_control_word[`CLK_SEL_HI:`CLK_SEL_LO];
	wire       self_sync = (second_control_word[`SYNC_SEL_HI:`SYNC_SEL_LO] == `SYNC_SELF) &&
		!second_control_word[`TRIG_BIT];
	wire       pwm_on = (mode == `MODE_EDGE_PWM) || (mode == `MODE_CENTER_PWM);
	wire       center = (mode == `MODE_CENTER_PWM);
	wire       fault_hit = |(fault_pins & fault_input_enables);
	wire       tick;

	tick_select u_tick (
		.core_clk      (core_clk),
		.sys_rst       (sys_rst),
		.clk_sel       (clk_sel),
		.prescale_tick (prescale_tick),
		.tick_reg      (tick)
	);

	// ************************************************************
	// helper functions
	// ************************************************************
	// equality of the count against a shadowed compare value
	function count_match;
		input [15:0] count;
		input [15:0] value;
		begin
			count_match = (count == value);
		end
	endfunction

	// wraps silently at the top; the period shadow keeps the count from getting there
	function [15:0] count_up;
		input [15:0] count;
		begin
			count_up = count + `CNT_ONE;
		end
	endfunction

	function [15:0] count_down;
		input [15:0] count;
		begin
			count_down = count - `CNT_ONE;
		end
	endfunction

	// bottom of a center-aligned cycle: one or zero while counting down
	function at_bottom;
		input [15:0] count;
		begin
			at_bottom = (count == `CNT_ZERO) || (count == `CNT_ONE);
		end
	endfunction

	// ************************************************************
	// shadow buffers and time base
	// ************************************************************
	reg [15:0] duty_shadow_reg;
	reg [15:0] end_shadow_reg;
	reg [15:0] period_shadow_reg;
	reg        down_reg;
	reg        started_reg;
	wire       at_period = count_match(timer_count_value, period_shadow_reg);
	wire       at_zero = count_match(timer_count_value, `CNT_ZERO);
	// edge mode: period match ends the cycle; center mode reloads at the bottom
	wire       reload = tick && (center ? (down_reg && at_bottom(timer_count_value)) : at_period);
	reg  [15:0] count_next;
	reg         down_next;

	always @* begin
		count_next = timer_count_value;
		down_next = down_reg;
		if (!center) begin
			down_next = 1'b0;
			count_next = at_period ? `CNT_ZERO : count_up(timer_count_value);
		end else if (!down_reg) begin
			if (at_period || count_match(period_shadow_reg, `CNT_ZERO)) begin
				down_next = 1'b1;
				count_next = at_zero ? `CNT_ZERO : count_down(timer_count_value);
			end else begin
				count_next = count_up(timer_count_value);
			end
		end else if (at_bottom(timer_count_value)) begin
			down_next = 1'b0;
			count_next = `CNT_ZERO;
		end else begin
			count_next = count_down(timer_count_value);
		end
	end

	always @(posedge core_clk) begin
		if (sys_rst || !pwm_on || !self_sync) begin
			timer_count_value <= `CNT_ZERO;
			down_reg <= 1'b0;
			started_reg <= 1'b0;
			duty_shadow_reg <= `CNT_ZERO;
			end_shadow_reg <= `CNT_ZERO;
			period_shadow_reg <= `CNT_ZERO;
		end else if (!started_reg) begin
			started_reg <= 1'b1;
			duty_shadow_reg <= primary_compare_value;
			end_shadow_reg <= secondary_compare_value;
			period_shadow_reg <= timer_period_value;
		end else if (tick) begin
			timer_count_value <= count_next;
			down_reg <= down_next;
			if (reload) begin
				duty_shadow_reg <= primary_compare_value;
				end_shadow_reg <= secondary_compare_value;
				period_shadow_reg <= timer_period_value;
			end
		end
	end

	// ************************************************************
	// output and flags
	// ************************************************************
	// the 16-bit counter bounds resolution to 16 bits; finer duty needs smaller prescale
	wire full_duty = (end_shadow_reg > period_shadow_reg);
	wire all_zero = (duty_shadow_reg == `CNT_ZERO) && (end_shadow_reg == `CNT_ZERO) &&
		(period_shadow_reg == `CNT_ZERO);
	wire hit_primary = started_reg && tick && count_match(timer_count_value, duty_shadow_reg);
	wire hit_secondary = started_reg && tick && count_match(timer_count_value, end_shadow_reg);
	reg  pin_next;
	reg  fault_next;
	reg  flag_next;

	// fault has the last word over every compare event
	always @* begin
		pin_next = pulse_output_pin;
		if (fault_active || fault_hit) begin
			pin_next = 1'b0;
		end else if (all_zero) begin
			pin_next = 1'b0;
		end else if (full_duty && hit_primary) begin
			pin_next = 1'b1;
		end else if (hit_secondary && !full_duty) begin
			pin_next = 1'b0;
		end else if (hit_primary) begin
			pin_next = 1'b1;
		end
	end

	// a unit that is not self-synchronised is stopped, so its pin is parked low too
	always @(posedge core_clk) begin
		if (sys_rst || !pwm_on || !self_sync) begin
			pulse_output_pin <= 1'b0;
		end else begin
			pulse_output_pin <= pin_next;
		end
	end

	// fault latches until software clears the compare flag with no fault present
	always @* begin
		fault_next = fault_active;
		if (fault_hit) begin
			fault_next = 1'b1;
		end else if (irq_flag_clear) begin
			fault_next = 1'b0;
		end
	end

	always @(posedge core_clk) begin
		if (sys_rst || !pwm_on) begin
			fault_active <= 1'b0;
		end else begin
			fault_active <= fault_next;
		end
	end

	// set wins over a clear landing in the same cycle
	always @* begin
		flag_next = compare_irq_flag;
		if ((pwm_on && hit_secondary) || fault_hit) begin
			flag_next = 1'b1;
		end else if (irq_flag_clear) begin
			flag_next = 1'b0;
		end
	end

	always @(posedge core_clk) begin
		if (sys_rst) begin
			compare_irq_flag <= 1'b0;
		end else begin
			compare_irq_flag <= flag_next;
		end
	end
endmodule
`default_nettype wire

/* verif/pwm_monitor.sv */
// checker for the pwm compare unit, bound onto its top module
// assumes control words change only while the unit is off
`timescale 1ns/100ps
`default_nettype none
module pwm_monitor (
	// watched ports
	input wire        core_clk,
	input wire        sys_rst,
	input wire [15:0] first_control_word,
	input wire [15:0] second_control_word,
	input wire [2:0]  fault_input_enables,
	input wire [15:0] primary_compare_value,
	input wire [15:0] secondary_compare_value,
	input wire [15:0] timer_period_value,
	input wire [2:0]  fault_pins,
	input wire        irq_flag_clear,
	input wire        pulse_output_pin,
	input wire        compare_irq_flag,
	input wire        fault_active,
	input wire [15:0] timer_count_value
);
	// ****
	// properties
	// ****
	wire run = first_control_word[2:1] == 2'h3 && {second_control_word[7], second_control_word[4:0]} == 6'h1f;
	wire zero = primary_compare_value == 16'h0000 && secondary_compare_value == 16'h0000 && timer_period_value == 16'h0000;
	wire edge7 = run && first_control_word[12:10] == 3'h7 && !first_control_word[0];
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	a_off_count_zero: assert property (!run [*2] |-> timer_count_value == 16'h0000) else $error("count not held");
	a_off_pin_low: assert property (!run [*2] |-> !pulse_output_pin) else $error("pin high while off");
	a_edge_count_step: assert property (edge7 && timer_count_value != 16'h0000 |-> timer_count_value == $past(timer_count_value) + 16'h0001) else $error("count step wrong");
	a_zero_duty_low: assert property ((run && zero) [*3] |-> !pulse_output_pin) else $error("zero duty pin high");
	a_fault_latch: assert property (run && |(fault_pins & fault_input_enables) |=> fault_active) else $error("fault missed");
	a_fault_forces_low: assert property (fault_active [*2] |-> !pulse_output_pin) else $error("pin high in fault");
	a_flag_sticky: assert property (compare_irq_flag && !irq_flag_clear |=> compare_irq_flag) else $error("flag lost");
	a_fall_sets_flag: assert property (run && $past(run) && !fault_active && $fell(pulse_output_pin) |-> compare_irq_flag) else $error("fall without flag");
	c_rise: cover property (run && $rose(pulse_output_pin));
	c_fault: cover property ($rose(fault_active));
	c_flag: cover property ($rose(compare_irq_flag));
endmodule
bind compare_unit_pwm_mode pwm_monitor u_mon (.core_clk, .sys_rst, .first_control_word, .second_control_word,
	.fault_input_enables, .primary_compare_value, .secondary_compare_value, .timer_period_value, .fault_pins,
	.irq_flag_clear, .pulse_output_pin, .compare_irq_flag, .fault_active, .timer_count_value);
`default_nettype wire

/* verif/pwm_load.sv */
// load on the pulse pin: measures period and high time between rises
// assumes the pin is a registered level on core_clk
`timescale 1ns/100ps
`default_nettype none
module pwm_load (
	// pin side
	input  wire         core_clk,
	input  wire         pulse_output_pin,
	// measurements, updated at each rise
	output logic [31:0] period_len = 0,
	output logic [31:0] high_len = 0,
	output logic [31:0] rises = 0
);
	// ****
	// measurement
	// ****
	logic [31:0] cyc = 0;
	logic [31:0] hi = 0;
	logic        last = 0;
	always @(posedge core_clk) begin
		last <= pulse_output_pin;
		if (pulse_output_pin && !last) begin
			period_len <= cyc;
			high_len <= hi;
			rises <= rises + 1;
			cyc <= 1;
			hi <= 1;
		end else begin
			cyc <= cyc + 1;
			hi <= hi + 32'(pulse_output_pin);
		end
	end
endmodule
`default_nettype wire

/* verif/compare_unit_pwm_mode_tb_top.sv */
// self-checking bench for the pwm compare unit
// assumes prescale tick 0 pulses every third cycle; config changes pass through mode off
`timescale 1ns/100ps
`default_nettype none
module compare_unit_pwm_mode_tb_top;
	// ****
	// stimulus and checks
	// ****
	logic        core_clk = 0, sys_rst = 1, irq_flag_clear = 0;
	logic [15:0] first_control_word = 0, second_control_word = 16'h001f;
	logic [15:0] primary_compare_value = 0, secondary_compare_value = 0, timer_period_value = 0;
	logic [3:0]  prescale_tick = 0;
	logic [2:0]  fault_input_enables = 0, fault_pins = 0;
	wire         pulse_output_pin, compare_irq_flag, fault_active;
	wire  [15:0] timer_count_value;
	wire  [31:0] period_len, high_len, rises;
	int          errors = 0, samples_checked = 0, p, a, b, tk = 0, s;
	compare_unit_pwm_mode u_dut (.core_clk, .sys_rst, .first_control_word, .second_control_word,
		.fault_input_enables, .primary_compare_value, .secondary_compare_value, .timer_period_value,
		.prescale_tick, .fault_pins, .irq_flag_clear, .pulse_output_pin, .compare_irq_flag, .fault_active,
		.timer_count_value);
	pwm_load u_load (.core_clk, .pulse_output_pin, .period_len, .high_len, .rises);
	initial forever #2.5 core_clk = ~core_clk;
	// unselected tick bits carry noise so a wrong selection shows
	always @(negedge core_clk) begin
		tk = (tk + 1) % 3;
		prescale_tick = {3'($urandom), tk == 0};
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic setup(input logic [15:0] cw, input logic [15:0] pri, input logic [15:0] sec, input logic [15:0] per);
		@(negedge core_clk) first_control_word = 16'h0000;
		primary_compare_value = pri;
		secondary_compare_value = sec;
		timer_period_value = per;
		repeat (2) @(negedge core_clk);
		first_control_word = cw;
	endtask
	function automatic int scaled(input int n, input int sc);
		return n * sc;
	endfunction
	task automatic end_of_test;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#200000;
		errors++;
		end_of_test;
	end
	initial begin
		s = $urandom(32'hbc7857bb);
		repeat (12) @(negedge core_clk);
		sys_rst = 0;
		for (int i = 0; i < 8; i++) begin
			p = 2 + $urandom % 20;
			a = (i == 0) ? 0 : $urandom % p;
			b = (i == 0) ? p : a + 1 + $urandom % (p - a);
			s = i[0] ? 3 : 1;
			setup(i[0] ? 16'h0006 : 16'h1c06, 16'(a), 16'(b), 16'(p));
			repeat (scaled(3 * (p + 1), s)) @(negedge core_clk);
			chk("period", scaled(p + 1, s), period_len);
			chk("high time", scaled(b - a, s), high_len);
		end
		@(posedge pulse_output_pin);
		@(negedge core_clk) secondary_compare_value = 16'(a + 1);
		@(posedge pulse_output_pin);
		repeat (2) @(negedge core_clk);
		chk("held duty", scaled(b - a, 3), high_len);
		@(posedge pulse_output_pin);
		repeat (2) @(negedge core_clk);
		chk("new duty", 3, high_len);
		setup(16'h1c06, 0, 0, 0);
		repeat (20) @(negedge core_clk) chk("zero duty pin", 0, 32'(pulse_output_pin));
		setup(16'h1c06, 1, 9, 5);
		repeat (20) @(negedge core_clk);
		chk("full duty pin", 1, 32'(pulse_output_pin));
		chk("flag held", 1, 32'(compare_irq_flag));
		for (int j = 0; j < 3; j++) begin
			irq_flag_clear = 1;
			@(negedge core_clk) irq_flag_clear = 0;
			fault_input_enables = 3'(1 << j);
			fault_pins = ~fault_input_enables;
			repeat (3) @(negedge core_clk);
			chk("masked fault", 0, 32'(fault_active));
			chk("flag cleared", 0, 32'(compare_irq_flag));
			fault_pins = fault_input_enables;
			repeat (3) @(negedge core_clk);
			chk("fault pin", 0, 32'(pulse_output_pin));
			fault_pins = 0;
		end
		setup(16'h1c07, 2, 4, 6);
		a = rises;
		repeat (80) @(negedge core_clk);
		chk("center pulses", 1, 32'(rises > a + 1));
		second_control_word = 16'h009f;
		repeat (4) @(negedge core_clk);
		chk("trigger held count", 0, 32'(timer_count_value));
		chk("trigger held pin", 0, 32'(pulse_output_pin));
		second_control_word = 16'h001f;
		setup(16'h1c00, 2, 4, 6);
		repeat (4) @(negedge core_clk);
		chk("off count", 0, 32'(timer_count_value));
		end_of_test;
	end
endmodule
`default_nettype wire
